//--- core/irq_ctrl_defines.svh
// Constants for the two-level interrupt controller: indices, positions, vectors, timing.
// Included by the controller file; it holds definitions only.
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

`define IRQ_SOURCE_COUNT 11
`define IRQ_VEC_COUNT 7
`define IRQ_FLAG_COUNT 9

// Flag vector positions
`define FLG_EXT_A 0
`define FLG_CTR_A 1
`define FLG_EXT_B 2
`define FLG_CTR_B 3
`define FLG_UART_RX 4
`define FLG_UART_TX 5
`define FLG_CTR_C_OVF 6
`define FLG_CTR_C_EXT 7
`define FLG_WDT 8
`define FLAGS_RESET 9'h000

// Enable and watchdog control register bit positions
`define IE_GLOBAL_BIT 7
`define EIE_WDT_BIT 4
`define WATCHDOG_CONTROL_REG_WDT_FLAG_BIT 3

// Machine cycle of four system clocks
`define MCYCLE_CLKS 4
`define MCYCLE_LAST 2'(`MCYCLE_CLKS - 1)

// Vector addresses
`define VEC_EXT_A 16'h0003
`define VEC_CTR_A 16'h000B
`define VEC_EXT_B 16'h0013
`define VEC_CTR_B 16'h001B
`define VEC_UART 16'h0023
`define VEC_CTR_C 16'h002B
`define VEC_WDT 16'h0063
`define VEC_RESET 16'h0000

`endif

//--- core/irq_ctrl_pkg.sv
// Types shared by the interrupt controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package irq_ctrl_pkg;
  // Source order is also the fixed grant order, first wins
  typedef enum logic [2:0] {
    SRC_EXT_A = 3'h0,
    SRC_CTR_A = 3'h1,
    SRC_EXT_B = 3'h2,
    SRC_CTR_B = 3'h3,
    SRC_UART = 3'h4,
    SRC_CTR_C = 3'h5,
    SRC_WDT = 3'h6
  } src_t;
endpackage

//--- core/pin_sampler.sv
// Pin sampler: three-flop synchroniser, agreement filter, machine-cycle sample, fall detect.
// Assumes tick_in pulses once per machine cycle and rst_n_in is already synchronised.
module pin_sampler (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic tick_in,
  output logic sample_out,
  output logic fall_out
);
  logic s1_q, s2_q, s3_q, filt_q, filt_d, smp_q, smp_d, fall_q, fall_d;

  always_comb begin
    filt_d = filt_q;
    if (s2_q == s3_q) begin
      filt_d = s2_q;
    end
    smp_d = smp_q;
    fall_d = 1'b0;
    if (tick_in) begin
      smp_d = filt_q;
      // High in one sample, low in the next; needs a full cycle per level
      fall_d = smp_q & ~filt_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      filt_q <= 1'b1;
      smp_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      smp_q <= smp_d;
      fall_q <= fall_d;
    end
  end

  assign sample_out = smp_q;
  assign fall_out = fall_q;
endmodule

//--- core/two_level_irq_controller.sv
// Two-level interrupt controller: flags, enables, priority resolution, vector hand-off.
// Assumes the core pulses irq_ack_in while irq_req_out is high and irq_return_in on return.
//
// Contract
// - Seven sources with enable, priority, flag, vector
// - Each external pin selects edge or level
// - Edge mode: sampled high then low sets
// - Edge external flag clears on service entry
// - Level external flag survives service entry
// - Timer a/b overflow flags clear on service
// - Timer c request ORs its two flags
// - Timer c flags never cleared on service
// - Watchdog flag bit 3, enable bit 4
// - Software may set or clear any flag
// - Per-source enables plus blocking global enable
// - Each source picks high or low level
// - Lower level never preempts higher routine
// - Fixed order resolves same-level simultaneous requests
// - Fixed vector address per source
// - Machine cycle is four system clocks
`include "irq_ctrl_defines.svh"
module two_level_irq_controller (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic external_request_a_pin_in,
  input wire logic external_request_b_pin_in,
  input wire logic trigger_select_a_in,
  input wire logic trigger_select_b_in,
  input wire logic [7:0] irq_enable_reg_in,
  input wire logic [4:0] extra_irq_enable_reg_in,
  input wire logic [`IRQ_VEC_COUNT-1:0] priority_in,
  input wire logic counter_a_overflow_in,
  input wire logic counter_b_overflow_in,
  input wire logic counter_c_overflow_in,
  input wire logic counter_c_external_in,
  input wire logic uart_rx_done_in,
  input wire logic uart_tx_done_in,
  input wire logic watchdog_timeout_in,
  input wire logic [`IRQ_FLAG_COUNT-1:0] flag_set_in,
  input wire logic [`IRQ_FLAG_COUNT-1:0] flag_clr_in,
  input wire logic irq_ack_in,
  input wire logic irq_return_in,
  output logic irq_req_out,
  output logic [15:0] irq_vector_out,
  output irq_ctrl_pkg::src_t irq_source_out,
  output logic irq_level_out,
  output logic [1:0] active_level_out,
  output logic [`IRQ_FLAG_COUNT-1:0] flags_out,
  output logic [7:0] watchdog_control_reg_out
);
  import irq_ctrl_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] phase_q, phase_d;
  logic tick_q, tick_d;
  logic samp_a, fall_a, samp_b, fall_b;
  logic [`IRQ_FLAG_COUNT-1:0] flags_q, flags_d, hw_set, hw_clr;
  logic [`IRQ_VEC_COUNT-1:0] pend, en, req_hi, req_lo;
  logic req_q, req_d, lvl_q, lvl_d, ack_take;
  logic [1:0] act_q, act_d;
  src_t sel_q, sel_d;
  logic [15:0] vec_q, vec_d;
  logic [7:0] watchdog_control_reg_q, watchdog_control_reg_d;

  // Lowest index wins: that is the fixed hierarchy
  function automatic src_t first_src(input logic [`IRQ_VEC_COUNT-1:0] v);
    src_t s;
    s = SRC_WDT;
    for (int i = `IRQ_VEC_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        s = src_t'(i[2:0]);
      end
    end
    return s;
  endfunction

  function automatic logic [15:0] vec_addr(input src_t s);
    logic [15:0] a;
    unique case (s)
      SRC_EXT_A: a = `VEC_EXT_A;
      SRC_CTR_A: a = `VEC_CTR_A;
      SRC_EXT_B: a = `VEC_EXT_B;
      SRC_CTR_B: a = `VEC_CTR_B;
      SRC_UART: a = `VEC_UART;
      SRC_CTR_C: a = `VEC_CTR_C;
      SRC_WDT: a = `VEC_WDT;
      default: a = `VEC_RESET;
    endcase
    return a;
  endfunction

  // Reset released through two flops
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_comb begin
    phase_d = phase_q + 2'h1;
    tick_d = (phase_q == `MCYCLE_LAST);
  end

  pin_sampler u_samp_a (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .pin_in(external_request_a_pin_in),
    .tick_in(tick_q),
    .sample_out(samp_a),
    .fall_out(fall_a)
  );

  pin_sampler u_samp_b (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .pin_in(external_request_b_pin_in),
    .tick_in(tick_q),
    .sample_out(samp_b),
    .fall_out(fall_b)
  );

  assign ack_take = irq_ack_in & req_q;

  // Flag group
  always_comb begin
    hw_set = '0;
    hw_clr = '0;
    // Level mode tracks the sampled pin; the requester keeps it low
    hw_set[`FLG_EXT_A] = trigger_select_a_in ? fall_a : (tick_q & ~samp_a);
    hw_clr[`FLG_EXT_A] = ~trigger_select_a_in & tick_q & samp_a;
    hw_set[`FLG_EXT_B] = trigger_select_b_in ? fall_b : (tick_q & ~samp_b);
    hw_clr[`FLG_EXT_B] = ~trigger_select_b_in & tick_q & samp_b;
    hw_set[`FLG_CTR_A] = counter_a_overflow_in;
    hw_set[`FLG_CTR_B] = counter_b_overflow_in;
    hw_set[`FLG_UART_RX] = uart_rx_done_in;
    hw_set[`FLG_UART_TX] = uart_tx_done_in;
    hw_set[`FLG_CTR_C_OVF] = counter_c_overflow_in;
    hw_set[`FLG_CTR_C_EXT] = counter_c_external_in;
    hw_set[`FLG_WDT] = watchdog_timeout_in;
    if (ack_take) begin
      unique case (sel_q)
        SRC_EXT_A: hw_clr[`FLG_EXT_A] = trigger_select_a_in;
        SRC_CTR_A: hw_clr[`FLG_CTR_A] = 1'b1;
        SRC_EXT_B: hw_clr[`FLG_EXT_B] = trigger_select_b_in;
        SRC_CTR_B: hw_clr[`FLG_CTR_B] = 1'b1;
        default: hw_clr = hw_clr;
      endcase
    end
    // Set beats clear so an event in the clearing cycle survives
    flags_d = (flags_q & ~(hw_clr | flag_clr_in)) | hw_set | flag_set_in;
    watchdog_control_reg_d = 8'h00;
    watchdog_control_reg_d[`WATCHDOG_CONTROL_REG_WDT_FLAG_BIT] = flags_d[`FLG_WDT];
  end

  // Arbitration group
  always_comb begin
    pend = {flags_q[`FLG_WDT],
            flags_q[`FLG_CTR_C_OVF] | flags_q[`FLG_CTR_C_EXT],
            flags_q[`FLG_UART_RX] | flags_q[`FLG_UART_TX],
            flags_q[`FLG_CTR_B], flags_q[`FLG_EXT_B],
            flags_q[`FLG_CTR_A], flags_q[`FLG_EXT_A]};
    en = {extra_irq_enable_reg_in[`EIE_WDT_BIT], irq_enable_reg_in[5:0]};
    en = en & {`IRQ_VEC_COUNT{irq_enable_reg_in[`IE_GLOBAL_BIT]}};
    req_hi = pend & en & priority_in;
    req_lo = pend & en & ~priority_in;
    act_d = act_q;
    if (irq_return_in) begin
      act_d = act_q[1] ? {1'b0, act_q[0]} : 2'b00;
    end
    if (ack_take) begin
      act_d[lvl_q] = 1'b1;
    end
    req_d = 1'b0;
    sel_d = sel_q;
    lvl_d = lvl_q;
    // One quiet cycle after ack or return lets flags and levels settle
    if (!ack_take && !irq_return_in) begin
      if ((|req_hi) && !act_q[1]) begin
        req_d = 1'b1;
        sel_d = first_src(req_hi);
        lvl_d = 1'b1;
      end else if ((|req_lo) && (act_q == 2'b00)) begin
        req_d = 1'b1;
        sel_d = first_src(req_lo);
        lvl_d = 1'b0;
      end
    end
    vec_d = vec_addr(sel_d);
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      tick_q <= 1'b0;
      flags_q <= `FLAGS_RESET;
      watchdog_control_reg_q <= 8'h00;
      req_q <= 1'b0;
      sel_q <= SRC_EXT_A;
      lvl_q <= 1'b0;
      act_q <= 2'b00;
      vec_q <= `VEC_EXT_A;
    end else begin
      phase_q <= phase_d;
      tick_q <= tick_d;
      flags_q <= flags_d;
      watchdog_control_reg_q <= watchdog_control_reg_d;
      req_q <= req_d;
      sel_q <= sel_d;
      lvl_q <= lvl_d;
      act_q <= act_d;
      vec_q <= vec_d;
    end
  end

  assign irq_req_out = req_q;
  assign irq_vector_out = vec_q;
  assign irq_source_out = sel_q;
  assign irq_level_out = lvl_q;
  assign active_level_out = act_q;
  assign flags_out = flags_q;
  assign watchdog_control_reg_out = watchdog_control_reg_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  a_mcycle_period: assert property (tick_q |=> !tick_q [*3] ##1 tick_q)
    else $error("machine cycle is not four clocks");
  a_edge_flag_set: assert property (fall_a && trigger_select_a_in |=> flags_q[`FLG_EXT_A])
    else $error("edge did not set external flag a");
  a_edge_auto_clr: assert property (ack_take && sel_q == SRC_EXT_A && trigger_select_a_in
    && !fall_a && !flag_set_in[`FLG_EXT_A] |=> !flags_q[`FLG_EXT_A])
    else $error("edge flag a not cleared on service");
  a_level_flag_keep: assert property (ack_take && sel_q == SRC_EXT_A && !trigger_select_a_in
    && flags_q[`FLG_EXT_A] && !flag_clr_in[`FLG_EXT_A] |=> flags_q[`FLG_EXT_A])
    else $error("level flag a cleared on service");
  a_timer_auto_clr: assert property (ack_take && sel_q == SRC_CTR_B && !counter_b_overflow_in
    && !flag_set_in[`FLG_CTR_B] |=> !flags_q[`FLG_CTR_B])
    else $error("timer b flag not cleared on service");
  a_ctr_c_keep: assert property (ack_take && sel_q == SRC_CTR_C && flags_q[`FLG_CTR_C_EXT]
    && !flag_clr_in[`FLG_CTR_C_EXT] |=> flags_q[`FLG_CTR_C_EXT])
    else $error("timer c flag cleared on service");
  a_wdt_flag_bit: assert property (watchdog_timeout_in |=> watchdog_control_reg_out[3])
    else $error("watchdog flag not at bit 3");
  a_sw_set_flag: assert property (flag_set_in[`FLG_UART_TX] |=> flags_out[`FLG_UART_TX])
    else $error("software set lost");
  a_global_block: assert property (!irq_enable_reg_in[7] |=> !irq_req_out)
    else $error("request while globally disabled");
  a_no_preempt: assert property (act_q[1] |-> !(req_q && !lvl_q))
    else $error("low request during high routine");
  a_vector_map: assert property (req_q && sel_q == SRC_WDT |-> irq_vector_out == 16'h0063)
    else $error("watchdog vector wrong");
  a_order_fixed: assert property (req_q && sel_q == SRC_CTR_A && lvl_q |->
    !$past(req_hi[0]))
    else $error("lower source granted before external a");
  a_record_level: assert property (ack_take && lvl_q && !irq_return_in |=> act_q[1])
    else $error("high level not recorded");

  c_edge_grant: cover property (fall_a ##[1:20] (ack_take && sel_q == SRC_EXT_A));
  c_nested: cover property (act_q == 2'b01 ##[1:50] act_q == 2'b11);
  c_return: cover property (act_q[1] ##1 irq_return_in ##1 !act_q[1]);
  c_wdt_grant: cover property (ack_take && sel_q == SRC_WDT);
endmodule

//--- verification/core_model.sv
// Core model: takes presented requests after a chosen delay, returns on command.
// Assumes the controller's clock and the raw bench reset.
module core_model (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic irq_req_in,
  input wire logic [15:0] irq_vector_in,
  input wire logic auto_ack_in,
  input wire logic [2:0] ack_delay_in,
  input wire logic ret_cmd_in,
  output logic irq_ack_out,
  output logic irq_return_out,
  output logic [15:0] taken_vector_out,
  output int grants_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_ack_out <= 1'b0;
      irq_return_out <= 1'b0;
      taken_vector_out <= 16'h0000;
      grants_out <= 0;
      wait_q <= 3'h0;
    end else begin
      irq_return_out <= ret_cmd_in;
      if (irq_ack_out && irq_req_in) begin
        // Vector is taken in the ack cycle, while the request is still high
        taken_vector_out <= irq_vector_in;
        grants_out <= grants_out + 1;
        irq_ack_out <= 1'b0;
        wait_q <= 3'h0;
      end else if (irq_req_in && auto_ack_in && wait_q >= ack_delay_in) begin
        irq_ack_out <= 1'b1;
      end else if (irq_req_in && auto_ack_in) begin
        wait_q <= wait_q + 3'h1;
      end else begin
        irq_ack_out <= 1'b0;
        wait_q <= 3'h0;
      end
    end
  end
endmodule

//--- verification/testbench.sv
// Bench: priority model of integers against the controller, core model as partner.
// Assumes the controller and core model are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctrl_pkg::*;
  logic clk, rstn, pa, pb, ta, tb, auto, ret, req, ack, rtn, lvl;
  logic [7:0] en, wd;
  logic [4:0] xe;
  logic [6:0] pr, ev;
  logic [8:0] fs, fc, mf, fl;
  logic [2:0] dly;
  logic [15:0] vec, got;
  logic [1:0] act;
  src_t src;
  int grants, ng, failures, checked, k;
  logic [15:0] vt [7] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B, 16'h0063};
  logic [8:0] gm [7] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h030, 9'h0C0, 9'h100};

  two_level_irq_controller dut_u (.mclk_in(clk), .rstn_in(rstn),
    .external_request_a_pin_in(pa), .external_request_b_pin_in(pb),
    .trigger_select_a_in(ta), .trigger_select_b_in(tb), .irq_enable_reg_in(en),
    .extra_irq_enable_reg_in(xe), .priority_in(pr), .counter_a_overflow_in(ev[0]),
    .counter_b_overflow_in(ev[1]), .counter_c_overflow_in(ev[2]),
    .counter_c_external_in(ev[3]), .uart_rx_done_in(ev[4]), .uart_tx_done_in(ev[5]),
    .watchdog_timeout_in(ev[6]), .flag_set_in(fs), .flag_clr_in(fc), .irq_ack_in(ack),
    .irq_return_in(rtn), .irq_req_out(req), .irq_vector_out(vec), .irq_source_out(src),
    .irq_level_out(lvl), .active_level_out(act), .flags_out(fl),
    .watchdog_control_reg_out(wd));
  core_model core_u (.mclk_in(clk), .rstn_in(rstn), .irq_req_in(req), .irq_vector_in(vec),
    .auto_ack_in(auto), .ack_delay_in(dly), .ret_cmd_in(ret), .irq_ack_out(ack),
    .irq_return_out(rtn), .taken_vector_out(got), .grants_out(grants));

  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Event bits land on flags 1,3,6,7,4,5,8
  task automatic pulse(input logic [8:0] s, input logic [8:0] c, input logic [6:0] e);
    @(posedge clk);
    fs <= s;
    fc <= c;
    ev <= e;
    mf = (mf & ~c) | s | {e[6], e[3], e[2], e[5], e[4], e[1], 1'b0, e[0], 1'b0};
    @(posedge clk);
    fs <= 9'h000;
    fc <= 9'h000;
    ev <= 7'h00;
  endtask
  task automatic rti();
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    step(3);
  endtask
  // Grants are counted, so one taken during an earlier wait is not missed
  task automatic wgrant(input logic [15:0] e);
    for (int i = 0; i < 80 && grants == ng; i++) begin
      step(1);
    end
    if (grants == ng) begin
      failures++;
      $display("CHECK FAILED t=%0t no grant", $time);
      finish_test();
    end
    ng++;
    chk(got, e, "vector");
  endtask
  function automatic int pick(logic [8:0] f, logic [7:0] e, logic [4:0] x, logic [6:0] p);
    logic [6:0] r;
    r = {f[8], f[6] | f[7], f[4] | f[5], f[3:0]} & {x[4], e[5:0]};
    if (!e[7]) return -1;
    for (int l = 1; l >= 0; l--) begin
      for (int i = 0; i < 7; i++) begin
        if (r[i] && p[i] == l) return i;
      end
    end
    return -1;
  endfunction

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rstn, auto, ret, en, xe, pr, ev, fs, fc, mf, dly} = '0;
    {pa, pb, ta, tb} = 4'hF;
    void'($urandom(26453));
    step(2);
    rstn <= 1'b1;
    step(8);
    chk(16'(fl), 16'h0000, "flag reset");
    chk(16'({req, act}), 16'h0000, "idle after reset");
    chk(vec, 16'h0003, "vector after reset");
    en <= 8'hBF;
    xe <= 5'h10;
    dly <= 3'($urandom_range(0, 3));
    pulse(9'h005, 9'h000, 7'h7F);
    step(2);
    chk(16'(wd), 16'h0008, "watchdog flag");
    auto <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wgrant(vt[i]);
      step(2);
      mf &= ~(gm[i] & 9'h00F);
      chk(16'(fl), 16'(mf), "service clear");
      chk(16'(act), 16'h0001, "active low");
      pulse(9'h000, gm[i], 7'h00);
      rti();
    end
    auto <= 1'b0;
    for (int r = 0; r < 16; r++) begin
      en <= 8'($urandom());
      xe <= 5'($urandom());
      pr <= 7'($urandom());
      pulse(9'($urandom()), 9'h000, 7'h00);
      step(3);
      k = pick(mf, en, xe, pr);
      chk(16'(req), 16'(k >= 0), "request");
      if (k >= 0) begin
        chk(vec, vt[k], "vector");
        chk(16'(src), 16'(k), "source");
        chk(16'(lvl), 16'(pr[k]), "level");
      end
      pulse(9'h000, 9'h1FF, 7'h00);
    end
    en <= 8'hBF;
    pr <= 7'h01;
    auto <= 1'b1;
    pulse(9'h000, 9'h000, 7'h01);
    wgrant(16'h000B);
    pulse(9'h000, 9'h000, 7'h02);
    step(6);
    chk(16'(req), 16'h0000, "low blocked");
    pulse(9'h001, 9'h000, 7'h00);
    wgrant(16'h0003);
    step(2);
    chk(16'(act), 16'h0003, "nested");
    rti();
    chk(16'(act), 16'h0001, "high returned");
    rti();
    wgrant(16'h001B);
    rti();
    chk(16'(fl), 16'h0000, "all cleared");
    auto <= 1'b0;
    pa <= 1'b0;
    step(12);
    chk(16'(fl[0]), 16'h0001, "edge seen");
    pa <= 1'b1;
    step(12);
    auto <= 1'b1;
    wgrant(16'h0003);
    step(2);
    chk(16'(fl[0]), 16'h0000, "edge cleared");
    rti();
    tb <= 1'b0;
    pb <= 1'b0;
    wgrant(16'h0013);
    step(2);
    chk(16'(fl[2]), 16'h0001, "level kept");
    auto <= 1'b0;
    pb <= 1'b1;
    rti();
    step(16);
    chk(16'(fl[2]), 16'h0000, "level released");
    ta <= 1'b0;
    pa <= 1'b0;
    auto <= 1'b1;
    wgrant(16'h0003);
    step(2);
    chk(16'(fl[0]), 16'h0001, "level a kept");
    chk(16'(act), 16'h0002, "level a high active");
    finish_test();
  end
endmodule
